// [cpu_call_stack_and_fetch_pipeline_test.sv]
`timescale 1ns/1ns
`default_nettype none
module cpu_call_stack_and_fetch_pipeline_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, data_wdata, data_rdata, status_out, working_register, table_latch, w0;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] prog_addr;
  logic [15:0] prog_data;
  logic [11:0] data_addr;
  logic data_rd, data_wr, irq_hi, irq_lo, device_reset;
  logic [3:0] bank_select_register, phase_onehot;
  int error_cnt, checks, rd_seen, rst_cnt, n;
  csf_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .irq_hi(irq_hi), .irq_lo(irq_lo),
    .status_out(status_out), .working_register(working_register),
    .bank_select_register(bank_select_register), .table_latch(table_latch),
    .phase_onehot(phase_onehot), .device_reset(device_reset));
  csf_mem_model mem (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    if (k >= 20) begin
      error_cnt++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [15:0] op, input int cyc);
    mem.rom[0] <= op;
    repeat (cyc) @(posedge pclk);
    mem.rom[0] <= 16'h4000;
    repeat (20) @(posedge pclk);
  endtask
  always @(negedge pclk) begin
    if (presetn === 1'b1 && data_rd === 1'b1) begin
      rd_seen++;
      chk("read phase", 32'h2, {28'h0, phase_onehot});
    end
    if (presetn === 1'b1 && data_wr === 1'b1) begin
      chk("write phase", 32'h8, {28'h0, phase_onehot});
    end
    if (device_reset === 1'b1) begin
      rst_cnt++;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, irq_hi, irq_lo} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {error_cnt, checks, rd_seen, rst_cnt} = {4{32'h0}};
    repeat (6) @(posedge pclk);
    mem.rom[0] <= 16'h4000;
    presetn <= 1'b1;
    apb(1'b0, csf_pkg::RSP_OFFSET, 32'h0);
    chk("rsp reset", 32'h0, rd);
    apb(1'b0, csf_pkg::CFG_OFFSET, 32'h0);
    chk("cfg reset", 32'h1, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, csf_pkg::RSP_OFFSET, 32'h3F);
    apb(1'b0, csf_pkg::RSP_OFFSET, 32'h0);
    chk("rsp level", 32'h1F, rd);
    apb(1'b1, csf_pkg::TOS_OFFSET, 32'hFFFFFFFF);
    apb(1'b0, csf_pkg::TOS_OFFSET, 32'h0);
    chk("tos width", 32'h1FFFFF, rd);
    // Preset near full, then keep calling
    apb(1'b1, csf_pkg::CFG_OFFSET, 32'h0);
    apb(1'b1, csf_pkg::RSP_OFFSET, 32'h1E);
    run(16'h1000, 100);
    apb(1'b0, csf_pkg::RSP_OFFSET, 32'h0);
    chk("rsp full", 32'h9F, rd);
    apb(1'b1, csf_pkg::RSP_OFFSET, 32'h0);
    run(16'h2000, 40);
    apb(1'b0, csf_pkg::RSP_OFFSET, 32'h0);
    chk("rsp underflow", 32'h40, rd);
    chk("reset count", 32'h0, rst_cnt);
    apb(1'b1, csf_pkg::CFG_OFFSET, 32'h1);
    run(16'h2000, 40);
    chk("stack reset", 32'h1, {31'h0, rst_cnt > 0});
    apb(1'b0, csf_pkg::RSP_OFFSET, 32'h0);
    chk("flag kept", 32'h40, rd);
    apb(1'b1, csf_pkg::RSP_OFFSET, 32'h0);
    mem.rom[1] <= 16'h4000;
    run(16'h7055, 40);
    chk("operand read", 32'h1, {31'h0, rd_seen > 0});
    mem.rom[4] <= 16'h3800;
    mem.rom[12] <= 16'h3800;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      w0 = working_register;
      irq_hi <= (i == 0);
      irq_lo <= (i == 1);
      while (prog_addr !== (i == 0 ? csf_pkg::HI_VECTOR : csf_pkg::LO_VECTOR) && n < 100) begin
        n++;
        @(posedge pclk);
      end
      chk("vector", {11'h0, i == 0 ? csf_pkg::HI_VECTOR : csf_pkg::LO_VECTOR}, {11'h0, prog_addr});
      if (n >= 100) begin
        final_report();
      end
      irq_hi <= 1'b0;
      irq_lo <= 1'b0;
      repeat (40) @(posedge pclk);
      chk("working_register restored", {24'h0, w0}, {24'h0, working_register});
      apb(1'b0, csf_pkg::RSP_OFFSET, 32'h0);
      chk("rsp after irq", 32'h0, rd);
    end
    final_report();
  end
endmodule
`default_nettype wire

// [csf_core.sv]
// Summary of operation
// - Stack-full flag in bit 7 sets when stack fills or overflows.
// - Underflow flag in bit 6 sets on pop of empty stack.
// - Bits 4-0 hold level read/write; bit 5 reads zero.
// - Flags clear only by software or power-on; pointer resets to zero.
// - With error reset enabled, set flag then reset the device.
// - With error reset disabled, set flag without device reset.
// - One-entry hidden shadow of status, working, bank loaded on every interrupt.
// - Return from interrupt with fast option restores shadow values.
// - Fast call saves shadow; fast return restores from it.
// - High-priority interrupt overwrites shadow during low-priority service.
// - Adding working register to counter low byte advances by bytes, LSb zero.
// - Table read takes byte address from table pointer, byte into latch.
// - Clock divided by four into phases one to four.
// - Counter increments in phase one; instruction captured in phase four.
// - Instruction register loads in phase one; executes phases two to four.
// - Data operand read in phase two, result written in phase four.
// - Fetch overlaps execute; counter-changing instructions take two cycles.
// - Branch flushes fetched instruction and fetches target, one extra cycle.
// - Push increments pointer then writes; pop reads top then decrements.
// - Stack holds 31 entries of 21 bits; level zero has no storage.
// - With error reset disabled, pointer stops at 31; no overwrite.
// - Pop of empty loads zero to counter, pointer stays zero.
`timescale 1ns/1ns
`default_nettype none
module csf_core #(
  parameter int PC_W = 21,
  parameter int DEPTH = 31
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  // Data memory
  output logic [11:0] data_addr,
  output logic data_rd,
  output logic data_wr,
  output logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  // Interrupt vectoring
  input wire logic irq_hi,
  input wire logic irq_lo,
  // Core status
  output logic [7:0] status_out,
  output logic [7:0] working_register,
  output logic [3:0] bank_select_register,
  output logic [7:0] table_latch,
  output logic [3:0] phase_onehot,
  output logic device_reset
);
  logic [1:0] phase;
  logic [7:0] return_stack_pointer;
  logic [PC_W-1:0] stack_mem [1:DEPTH];
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] table_pointer;
  logic [15:0] fetch_word;
  logic [15:0] instruction_register;
  logic fetch_valid;
  logic exec_valid;
  logic stack_error_reset_enable;
  logic [7:0] status_reg;
  logic [7:0] shadow_status;
  logic [7:0] shadow_working;
  logic [3:0] shadow_bank;
  logic in_hi;
  logic in_lo;
  logic [7:0] operand;
  logic tbl_cycle;

  wire logic ph1 = phase == 2'd0;
  wire logic ph2 = phase == 2'd1;
  wire logic ph3_w = phase == 2'd2;
  wire logic ph4 = phase == 2'd3;
  wire logic [3:0] op = instruction_register[15:12];
  wire logic fast = instruction_register[11];
  wire logic [4:0] level = return_stack_pointer[4:0];
  wire logic live = exec_valid && !tbl_cycle;
  wire logic do_call = live && ph4 && op == csf_pkg::OP_CALL;
  wire logic do_ret = live && ph4 && (op == csf_pkg::OP_RETURN || op == csf_pkg::OP_RETURN_FROM_INTERRUPT);
  wire logic do_goto = live && ph4 && op == csf_pkg::OP_GOTO;
  wire logic do_add = live && ph4 && op == csf_pkg::OP_ADDPCL;
  // No vectoring inside a table-read cycle, the fetch slot is busy
  wire logic take_irq = ph4 && !tbl_cycle &&
                        ((irq_hi && !in_hi) || (irq_lo && !in_hi && !in_lo));
  wire logic push = do_call || take_irq;
  wire logic full_now = push && level >= 5'(DEPTH - 1);
  wire logic unf_now = do_ret && level == 5'h00;
  wire logic stk_err = full_now || unf_now;
  wire logic branch = do_call || do_ret || do_goto || do_add || take_irq;
  wire logic apb_acc = psel && penable;
  wire logic wr_rsp = apb_acc && pwrite && paddr == csf_pkg::RSP_OFFSET;
  wire logic wr_cfg = apb_acc && pwrite && paddr == csf_pkg::CFG_OFFSET;
  wire logic wr_tos = apb_acc && pwrite && paddr == csf_pkg::TOS_OFFSET && level != 5'h00;
  wire logic mapped = paddr == csf_pkg::RSP_OFFSET || paddr == csf_pkg::CFG_OFFSET ||
                      paddr == csf_pkg::TOS_OFFSET || paddr == csf_pkg::PC_OFFSET ||
                      paddr == csf_pkg::STAT_OFFSET;
  wire logic [PC_W-1:0] top_of_stack_entry = level == 5'h00 ? '0 : stack_mem[level];
  wire logic [PC_W-1:0] target_addr = {instruction_register[10:0], 10'h000} >> 9;
  wire logic [PC_W-1:0] add_target = {pc[PC_W-1:8],
                                      8'(pc[7:0] + {working_register[7:1], 1'b0})};

  assign pready = 1'b1;
  assign pslverr = apb_acc && !mapped;
  // Fetch address lags the counter, which already moved on in phase one
  assign prog_addr = tbl_cycle ? table_pointer : pc - csf_pkg::PC_STEP;
  assign status_out = status_reg;
  assign phase_onehot = 4'b0001 << phase;

  // Four-phase divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase <= 2'd0;
    else phase <= phase + 2'd1;
  end

  // Device reset pulse on stack error when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) device_reset <= 1'b0;
    else device_reset <= stk_err && stack_error_reset_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stack_error_reset_enable <= csf_pkg::CFG_RESET;
    else if (wr_cfg) stack_error_reset_enable <= pwdata[0];
  end

  // Stack pointer, flags and storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_stack_pointer <= csf_pkg::RSP_RESET;
    end else begin
      if (wr_rsp) begin
        return_stack_pointer[4:0] <= pwdata[4:0];
        if (!pwdata[csf_pkg::FULL_BIT]) return_stack_pointer[csf_pkg::FULL_BIT] <= 1'b0;
        if (!pwdata[csf_pkg::UNF_BIT]) return_stack_pointer[csf_pkg::UNF_BIT] <= 1'b0;
      end
      if (push) begin
        if (full_now && stack_error_reset_enable) return_stack_pointer[4:0] <= 5'h00;
        else if (level != csf_pkg::LEVEL_MAX) return_stack_pointer[4:0] <= level + 5'h01;
        if (full_now) return_stack_pointer[csf_pkg::FULL_BIT] <= 1'b1;
      end
      if (do_ret) begin
        if (unf_now) return_stack_pointer[csf_pkg::UNF_BIT] <= 1'b1;
        else return_stack_pointer[4:0] <= level - 5'h01;
      end
      if (stk_err && stack_error_reset_enable && !push) return_stack_pointer[4:0] <= 5'h00;
      return_stack_pointer[5] <= 1'b0;
    end
  end

  generate
    for (genvar i = 1; i <= DEPTH; i++) begin : g_stk
      always_ff @(posedge pclk) begin
        if (push && level != csf_pkg::LEVEL_MAX && level + 5'h01 == 5'(i))
          stack_mem[i] <= pc - csf_pkg::PC_STEP;
        else if (wr_tos && level == 5'(i))
          stack_mem[i] <= pwdata[PC_W-1:0];
      end
    end
  endgenerate

  // Fetch and execute pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= csf_pkg::PC_RESET;
      fetch_word <= 16'h0000;
      fetch_valid <= 1'b0;
      instruction_register <= 16'h0000;
      exec_valid <= 1'b0;
      tbl_cycle <= 1'b0;
    end else if (device_reset) begin
      pc <= csf_pkg::PC_RESET;
      fetch_valid <= 1'b0;
      exec_valid <= 1'b0;
      tbl_cycle <= 1'b0;
    end else begin
      // Table-read cycle stalls the pipeline for one instruction cycle
      if (ph1 && !tbl_cycle) begin
        instruction_register <= fetch_word;
        exec_valid <= fetch_valid;
        pc <= pc + csf_pkg::PC_STEP;
      end
      if (ph4) begin
        tbl_cycle <= 1'b0;
        if (!tbl_cycle) fetch_word <= prog_data;
        if (!tbl_cycle) fetch_valid <= !branch;
        if (take_irq) pc <= irq_hi ? csf_pkg::HI_VECTOR : csf_pkg::LO_VECTOR;
        else if (do_call || do_goto) pc <= target_addr;
        else if (do_ret) pc <= unf_now ? '0 : top_of_stack_entry;
        else if (do_add) pc <= add_target;
      end
      if (live && ph4 && op == csf_pkg::OP_TBLRD) tbl_cycle <= 1'b1;
    end
  end

  // Table read: byte from program memory at table pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_pointer <= '0;
      table_latch <= 8'h00;
    end else begin
      if (live && ph2 && op == csf_pkg::OP_TBLRD) table_pointer <= {instruction_register[10:0], 10'h000} >> 10;
      if (tbl_cycle && ph4)
        table_latch <= table_pointer[0] ? prog_data[15:8] : prog_data[7:0];
    end
  end

  // Data memory access and register file of working, status and bank
  always_comb begin
    data_addr = {bank_select_register, instruction_register[7:0]};
    data_rd = live && ph2 && op == csf_pkg::OP_DATA;
    data_wr = live && ph4 && op == csf_pkg::OP_DATA;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand <= 8'h00;
      data_wdata <= 8'h00;
      working_register <= 8'h00;
      status_reg <= 8'h00;
      bank_select_register <= 4'h0;
      shadow_status <= 8'h00;
      shadow_working <= 8'h00;
      shadow_bank <= 4'h0;
      in_hi <= 1'b0;
      in_lo <= 1'b0;
    end else begin
      if (data_rd) operand <= data_rdata;
      if (live && ph3_w) data_wdata <= operand + working_register;
      if (data_wr) begin
        working_register <= data_wdata;
        status_reg[2] <= data_wdata == 8'h00;
        bank_select_register <= instruction_register[11:8];
      end
      if (take_irq || (do_call && fast)) begin
        shadow_status <= status_reg;
        shadow_working <= working_register;
        shadow_bank <= bank_select_register;
      end
      if (take_irq) begin
        if (irq_hi) in_hi <= 1'b1;
        else in_lo <= 1'b1;
      end
      if (do_ret && fast) begin
        status_reg <= shadow_status;
        working_register <= shadow_working;
        bank_select_register <= shadow_bank;
      end
      if (do_ret && op == csf_pkg::OP_RETURN_FROM_INTERRUPT) begin
        if (in_hi) in_hi <= 1'b0;
        else in_lo <= 1'b0;
      end
    end
  end

  // Register reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        csf_pkg::RSP_OFFSET: prdata <= {24'h000000, return_stack_pointer};
        csf_pkg::CFG_OFFSET: prdata <= {31'h00000000, stack_error_reset_enable};
        csf_pkg::TOS_OFFSET: prdata <= {11'h000, top_of_stack_entry};
        csf_pkg::PC_OFFSET: prdata <= {11'h000, pc};
        csf_pkg::STAT_OFFSET: prdata <= {20'h00000, bank_select_register, working_register};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  AST_FULL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    full_now |=> return_stack_pointer[7]) else $error("full flag not set");
  AST_UNF_SET: assert property (@(posedge pclk) disable iff (!presetn)
    unf_now |=> return_stack_pointer[6] && return_stack_pointer[4:0] == 5'h00)
    else $error("underflow not flagged");
  AST_BIT5: assert property (@(posedge pclk) disable iff (!presetn)
    !return_stack_pointer[5]) else $error("bit 5 set");
  AST_ERR_RST: assert property (@(posedge pclk) disable iff (!presetn)
    stk_err && stack_error_reset_enable |=> device_reset) else $error("no reset");
  AST_NO_RST: assert property (@(posedge pclk) disable iff (!presetn)
    stk_err && !stack_error_reset_enable |=> !device_reset) else $error("bad reset");
  AST_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
    ph1 |=> ph2 ##1 ph3_w ##1 ph4) else $error("phase order");
  AST_STOP31: assert property (@(posedge pclk) disable iff (!presetn)
    push && level == 5'h1F && !stack_error_reset_enable && !wr_rsp |=> level == 5'h1F)
    else $error("pointer passed 31");
  AST_FLUSH: assert property (@(posedge pclk) disable iff (!presetn)
    branch && !device_reset |=> !fetch_valid) else $error("no flush");
  AST_PUSH_INC: assert property (@(posedge pclk) disable iff (!presetn)
    push && level < 5'h1E && !wr_rsp |=> level == $past(level) + 5'h01)
    else $error("push step");

  AST_POP_DEC: assert property (@(posedge pclk) disable iff (!presetn)
    do_ret && !unf_now && !push && !wr_rsp |=> level == $past(level) - 5'h01)
    else $error("pop step");

  AST_UNF_PC: assert property (@(posedge pclk) disable iff (!presetn)
    unf_now && !take_irq && !device_reset |=> pc == '0)
    else $error("underflow pc not zero");

  AST_FULL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    full_now && stack_error_reset_enable && !do_ret |=> level == 5'h00)
    else $error("pointer not cleared on full");

  AST_FULL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    return_stack_pointer[7] && !wr_rsp |=> return_stack_pointer[7])
    else $error("full flag lost");

  AST_UNF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    return_stack_pointer[6] && !wr_rsp |=> return_stack_pointer[6])
    else $error("underflow flag lost");

  AST_WR_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    wr_rsp && !push && !do_ret |=> level == $past(pwdata[4:0]))
    else $error("level write lost");

  AST_RST_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    device_reset |=> !device_reset)
    else $error("reset pulse too long");

  AST_SHADOW_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    take_irq |=> shadow_working == $past(working_register) &&
      shadow_status == $past(status_reg) && shadow_bank == $past(bank_select_register))
    else $error("shadow not loaded");

  AST_FAST_RESTORE: assert property (@(posedge pclk) disable iff (!presetn)
    do_ret && fast |=> working_register == $past(shadow_working) &&
      status_reg == $past(shadow_status) && bank_select_register == $past(shadow_bank))
    else $error("shadow not restored");

  AST_FAST_CALL: assert property (@(posedge pclk) disable iff (!presetn)
    do_call && fast |=> shadow_working == $past(working_register))
    else $error("fast call not saved");

  AST_HI_OVER: assert property (@(posedge pclk) disable iff (!presetn)
    ph4 && !tbl_cycle && irq_hi && in_lo && !in_hi |-> take_irq)
    else $error("high priority not taken");

  AST_ADD_LSB: assert property (@(posedge pclk) disable iff (!presetn)
    do_add && !pc[0] && !take_irq && !device_reset |=> !pc[0])
    else $error("computed jump odd");

  AST_TBL_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    tbl_cycle |-> prog_addr == table_pointer)
    else $error("table address");

  AST_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(phase_onehot))
    else $error("phase not one-hot");

  AST_PC_PH1: assert property (@(posedge pclk) disable iff (!presetn)
    ph1 && !tbl_cycle && !device_reset |=> pc == $past(pc) + csf_pkg::PC_STEP)
    else $error("pc not stepped");

  AST_FETCH_PH4: assert property (@(posedge pclk) disable iff (!presetn)
    ph4 && !tbl_cycle && !device_reset |=> fetch_word == $past(prog_data))
    else $error("fetch not captured");

  AST_IR_PH1: assert property (@(posedge pclk) disable iff (!presetn)
    ph1 && !tbl_cycle && !device_reset |=> instruction_register == $past(fetch_word))
    else $error("instruction not loaded");

  AST_RD_PH2: assert property (@(posedge pclk) disable iff (!presetn)
    data_rd |-> ph2)
    else $error("read outside phase two");

  AST_WR_PH4: assert property (@(posedge pclk) disable iff (!presetn)
    data_wr |-> ph4)
    else $error("write outside phase four");

  AST_FLUSH_EXEC: assert property (@(posedge pclk) disable iff (!presetn)
    branch |-> ##2 !exec_valid)
    else $error("flushed word executed");
endmodule
`default_nettype wire

// [csf_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module csf_mem_model (
  // Clock
  input wire logic pclk,
  // Program memory
  input wire logic [20:0] prog_addr,
  output logic [15:0] prog_data,
  // Data memory
  input wire logic [11:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata
);
  logic [15:0] rom [0:63];
  logic [7:0] ram [0:4095];
  logic [7:0] last_rd;
  initial begin
    for (int i = 0; i < 64; i++) begin
      rom[i] = 16'h0000;
    end
    for (int i = 0; i < 4096; i++) begin
      ram[i] = 8'h00;
    end
    last_rd = 8'h00;
  end
  // Space beyond the table reads as a no-op
  assign prog_data = (prog_addr[20:7] == 14'h0000) ? rom[prog_addr[6:1]] : 16'h0000;
  // Not strobed: bus shows the inverse of the last value
  assign data_rdata = data_rd ? ram[data_addr] : ~last_rd;
  always @(posedge pclk) begin
    last_rd <= data_rdata;
    if (data_wr) begin
      ram[data_addr] <= data_wdata;
    end
  end
endmodule
`default_nettype wire

// [csf_pkg.sv]
package csf_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] RSP_OFFSET = 8'h00;
  localparam logic [7:0] CFG_OFFSET = 8'h04;
  localparam logic [7:0] TOS_OFFSET = 8'h08;
  localparam logic [7:0] PC_OFFSET = 8'h0C;
  localparam logic [7:0] STAT_OFFSET = 8'h10;
  // Return stack pointer field positions
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam logic [7:0] RSP_RESET = 8'h00;
  localparam logic [4:0] LEVEL_MAX = 5'h1F;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] HI_VECTOR = 21'h000008;
  localparam logic [20:0] LO_VECTOR = 21'h000018;
  // Config: stack error reset enable resets to set
  localparam logic CFG_RESET = 1'b1;
  typedef enum logic [1:0] {CSF_PH1, CSF_PH2, CSF_PH3, CSF_PH4} csf_phase_t;
  // Instruction control codes taken from the fetched word
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_CALL = 4'h1;
  localparam logic [3:0] OP_RETURN = 4'h2;
  localparam logic [3:0] OP_RETURN_FROM_INTERRUPT = 4'h3;
  localparam logic [3:0] OP_GOTO = 4'h4;
  localparam logic [3:0] OP_ADDPCL = 4'h5;
  localparam logic [3:0] OP_TBLRD = 4'h6;
  localparam logic [3:0] OP_DATA = 4'h7;
endpackage
